// ===== hw/adcc_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

`define ADCC_ADDR_W 3
`define ADCC_OFF_CTRL 3'h0
`define ADCC_OFF_RES_LO 3'h1
`define ADCC_OFF_RES_HI 3'h2
`define ADCC_OFF_INSEL 3'h3
`define ADCC_OFF_SFR 3'h4

`define ADCC_CTRL_EN 7
`define ADCC_CTRL_START 6
`define ADCC_CTRL_FREE 5
`define ADCC_CTRL_FLAG 4
`define ADCC_CTRL_IRQEN 3
`define ADCC_INSEL_LADJ 5
`define ADCC_SFR_HS 4

`define ADCC_CTRL_RESET 8'h00
`define ADCC_INSEL_RESET 8'h00
`define ADCC_SFR_RESET 8'h00
`define ADCC_RESULT_RESET 10'h000

`define ADCC_FIRST_CYC 5'h19
`define ADCC_NORMAL_CYC 5'h0d

`endif

// ===== hw/adcc_pkg.sv
// types shared by the conversion control modules
package adcc_pkg;

	typedef enum logic {ADCC_IDLE, ADCC_CONV} adcc_state_e;

	typedef logic [9:0] adcc_result_t;

	typedef struct packed {
		logic [6:0] cnt_r;
		logic tick_r;
	} adcc_presc_s;

	typedef struct packed {
		adcc_state_e state_r;
		logic enable_r;
		logic busy_r;
		logic free_r;
		logic flag_r;
		logic irq_en_r;
		logic [2:0] div_sel_r;
		logic left_adj_r;
		logic [3:0] channel_r;
		logic [1:0] ref_r;
		logic high_speed_r;
		logic [3:0] act_channel_r;
		logic [1:0] act_ref_r;
		logic first_pend_r;
		logic long_conv_r;
		logic [4:0] cyc_r;
		adcc_result_t result_r;
		logic locked_r;
		logic sample_r;
		logic irq_r;
		logic [7:0] rdata_r;
	} adcc_regs_s;

endpackage : adcc_pkg

// ===== hw/adcc_prescaler.sv
// converter clock prescaler producing one tick per divided period
`include "adcc_defines.svh"

module adcc_prescaler
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// control
	input wire logic enable,
	input wire logic [2:0] div_sel,
	input wire logic high_speed,
	// converter clock tick
	output logic tick
);

	adcc_presc_s s_r;
	adcc_presc_s s_nxt;
	logic [2:0] shift;
	logic [6:0] last;

	always_comb
	begin
		shift = (div_sel == 3'h0) ? 3'h1 : div_sel;
		if (high_speed && shift > 3'h1)
			shift = shift - 3'h1;
		last = 7'((8'h01 << shift) - 8'h01);
		s_nxt = s_r;
		s_nxt.tick_r = 1'b0;
		if (!enable)
			s_nxt.cnt_r = 7'h00;
		else if (s_r.cnt_r >= last)
		begin
			s_nxt.cnt_r = 7'h00;
			s_nxt.tick_r = 1'b1;
		end
		else
			s_nxt.cnt_r = s_r.cnt_r + 7'h01;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick_r;

endmodule : adcc_prescaler

// ===== hw/adcc_top.sv
// conversion control for a 10-bit converter with its register file
// Function
// - enable bit powers the converter; clearing it aborts a running conversion
// - single mode: each conversion starts on a written one to start bit
// - first conversion after enable lasts 25 converter clocks, later ones 13
// - start bit reads one while converting, clears itself on completion unless free-running starts the next conversion
// - writing zero to the start bit is ignored
// - free-running select converts back to back; clearing it stops this
// - done flag sets when a conversion ends and results are updated
// - interrupt request when flag, interrupt enable and global enable are set
// - done flag clears when the processor vectors to the handler
// - writing one to done flag clears it; zero leaves it
// - divider select: codes 0,1 divide by 2, then 4 up to 128
// - after low byte read, results freeze until high byte read
// - right adjust: high byte holds bits 9:8, low byte bits 7:0
// - left adjust: high byte holds bits 9:2, low byte bits 1:0 on top
// - high-speed select halves the divider for codes 2 to 7, giving a faster conversion rate
// - left-adjust changes take effect on the result view at once
// - channel and reference changes apply only after the running conversion
// - result code 0x000 is ground, 0x3FF is reference minus one step
//
// Decided for this implementation: the plain strobed port and the address map.
`include "adcc_defines.svh"

module adcc_top
	import adcc_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	// register port
	input wire logic [`ADCC_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// processor interrupt
	input wire logic GLOBAL_IRQ_EN,
	input wire logic IRQ_ACK,
	output logic IRQ,
	// analog front end
	input wire adcc_pkg::adcc_result_t ANA_RESULT,
	output logic ANA_POWER,
	output logic ANA_SAMPLE,
	output logic ANA_HIGH_SPEED,
	output logic [3:0] ANA_CHANNEL,
	output logic [1:0] ANA_REF
);

	adcc_regs_s s_r;
	adcc_regs_s n;
	logic tick;
	logic [4:0] last_cyc;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic wr_ctrl;
	logic do_start;

	adcc_prescaler u_presc (
		.clk(CLK_SYS),
		.resetn(RESETN),
		.enable(s_r.enable_r),
		.div_sel(s_r.div_sel_r),
		.high_speed(s_r.high_speed_r),
		.tick(tick)
	);

	always_comb
	begin
		n = s_r;
		n.sample_r = 1'b0;
		n.rdata_r = 8'h00;
		do_start = 1'b0;
		wr_ctrl = WR && ADDR == `ADCC_OFF_CTRL;
		last_cyc = s_r.long_conv_r ? `ADCC_FIRST_CYC - 5'h01 :
			`ADCC_NORMAL_CYC - 5'h01;

		// result view follows the present adjust setting
		if (s_r.left_adj_r)
		begin
			res_hi = s_r.result_r[9:2];
			res_lo = {s_r.result_r[1:0], 6'h00};
		end
		else
		begin
			res_hi = {6'h00, s_r.result_r[9:8]};
			res_lo = s_r.result_r[7:0];
		end

		// register reads
		if (RD)
		begin
			unique case (ADDR)
				`ADCC_OFF_CTRL:
					n.rdata_r = {s_r.enable_r, s_r.busy_r, s_r.free_r,
						s_r.flag_r, s_r.irq_en_r, s_r.div_sel_r};
				`ADCC_OFF_RES_LO:
				begin
					n.rdata_r = res_lo;
					n.locked_r = 1'b1;
				end
				`ADCC_OFF_RES_HI:
				begin
					n.rdata_r = res_hi;
					n.locked_r = 1'b0;
				end
				`ADCC_OFF_INSEL:
					n.rdata_r = {s_r.ref_r, s_r.left_adj_r, 1'b0,
						s_r.channel_r};
				`ADCC_OFF_SFR:
					n.rdata_r = {3'h0, s_r.high_speed_r, 4'h0};
				default:
					n.rdata_r = 8'h00;
			endcase
		end

		// flag clears come first so a same-cycle completion wins
		if (IRQ_ACK)
			n.flag_r = 1'b0;
		if (wr_ctrl && WDATA[`ADCC_CTRL_FLAG])
			n.flag_r = 1'b0;

		// register writes
		if (wr_ctrl)
		begin
			n.enable_r = WDATA[`ADCC_CTRL_EN];
			n.free_r = WDATA[`ADCC_CTRL_FREE];
			n.irq_en_r = WDATA[`ADCC_CTRL_IRQEN];
			n.div_sel_r = WDATA[2:0];
			if (WDATA[`ADCC_CTRL_EN] && !s_r.enable_r)
				n.first_pend_r = 1'b1;
		end
		if (WR && ADDR == `ADCC_OFF_INSEL)
		begin
			n.ref_r = WDATA[7:6];
			n.left_adj_r = WDATA[`ADCC_INSEL_LADJ];
			n.channel_r = WDATA[3:0];
		end
		if (WR && ADDR == `ADCC_OFF_SFR)
			n.high_speed_r = WDATA[`ADCC_SFR_HS];

		// conversion sequencing
		if (!n.enable_r)
		begin
			n.state_r = ADCC_IDLE;
			n.busy_r = 1'b0;
			n.cyc_r = 5'h00;
		end
		else
		begin
			unique case (s_r.state_r)
				ADCC_IDLE:
					// a written zero does nothing
					if (wr_ctrl && WDATA[`ADCC_CTRL_START])
						do_start = 1'b1;
				ADCC_CONV:
					if (tick)
					begin
						if (s_r.cyc_r == last_cyc)
						begin
							n.busy_r = 1'b0;
							n.state_r = ADCC_IDLE;
							if (!s_r.locked_r)
							begin
								n.result_r = ANA_RESULT;
								n.flag_r = 1'b1;
							end
							if (n.free_r)
								do_start = 1'b1;
						end
						else
							n.cyc_r = s_r.cyc_r + 5'h01;
					end
			endcase
		end

		if (do_start)
		begin
			n.state_r = ADCC_CONV;
			n.busy_r = 1'b1;
			n.cyc_r = 5'h00;
			n.long_conv_r = n.first_pend_r;
			n.first_pend_r = 1'b0;
			n.sample_r = 1'b1;
		end

		// selections reach the front end only between conversions
		if (n.state_r == ADCC_IDLE || do_start)
		begin
			n.act_channel_r = n.channel_r;
			n.act_ref_r = n.ref_r;
		end

		n.irq_r = n.flag_r && n.irq_en_r && GLOBAL_IRQ_EN;
	end

	always_ff @(posedge CLK_SYS or negedge RESETN)
	begin
		if (!RESETN)
		begin
			s_r <= '0;
			s_r.state_r <= ADCC_IDLE;
			s_r.result_r <= `ADCC_RESULT_RESET;
		end
		else
			s_r <= n;
	end

	assign RDATA = s_r.rdata_r;
	assign IRQ = s_r.irq_r;
	assign ANA_POWER = s_r.enable_r;
	assign ANA_SAMPLE = s_r.sample_r;
	assign ANA_HIGH_SPEED = s_r.high_speed_r;
	assign ANA_CHANNEL = s_r.act_channel_r;
	assign ANA_REF = s_r.act_ref_r;

endmodule : adcc_top

// ===== testbench/adcc_assertions.sv
// port assertions for the conversion control block
`include "adcc_defines.svh"
module adcc_chk (
	input wire logic CLK_SYS, RESETN, WR, RD, GLOBAL_IRQ_EN,
	input wire logic IRQ, ANA_POWER, ANA_SAMPLE, ANA_HIGH_SPEED,
	input wire logic [`ADCC_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA, RDATA,
	input wire logic [3:0] ANA_CHANNEL,
	input wire logic [1:0] ANA_REF
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	wire wc = WR && ADDR == `ADCC_OFF_CTRL;
	wire ws = WR && ADDR == `ADCC_OFF_SFR;
	sequence s_quiet;
		!ANA_SAMPLE [*8];
	endsequence
	a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not zero");
	a_power_follow: assert property (wc |=> ANA_POWER == $past(WDATA[7]))
		else $error("power does not follow enable");
	a_sample_pwr: assert property (ANA_SAMPLE |-> ANA_POWER)
		else $error("sample while off");
	a_no_start: assert property (!ANA_POWER && !(wc && WDATA[7]) |=> !ANA_SAMPLE)
		else $error("start while off");
	a_sample_gap: assert property (ANA_SAMPLE |=> s_quiet)
		else $error("conversion too short");
	a_sel_frozen: assert property (ANA_SAMPLE |=>
		($stable(ANA_CHANNEL) && $stable(ANA_REF)) [*8])
		else $error("selection moved in conversion");
	a_irq_gated: assert property (!GLOBAL_IRQ_EN |=> !IRQ)
		else $error("request without global enable");
	a_hs_follow: assert property (ws |=> ANA_HIGH_SPEED == $past(WDATA[4]))
		else $error("high speed does not follow");
endmodule : adcc_chk
bind adcc_top adcc_chk u_adcc_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
	.WR(WR), .RD(RD), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .IRQ(IRQ),
	.ANA_POWER(ANA_POWER), .ANA_SAMPLE(ANA_SAMPLE), .ADDR(ADDR),
	.ANA_HIGH_SPEED(ANA_HIGH_SPEED), .WDATA(WDATA), .RDATA(RDATA),
	.ANA_CHANNEL(ANA_CHANNEL), .ANA_REF(ANA_REF));

// ===== testbench/tb_adcc_top.sv
// self-checking bench for the conversion control block
module tb_adcc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adcc_pkg::*;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, gie = 0, ack = 0;
	logic [2:0] addr = 0;
	logic [7:0] wd = 0, rdat;
	adcc_result_t res = 10'h2d5;
	logic irq, pwr, smp, hs;
	logic [3:0] ch;
	logic [1:0] rf;
	int err_count = 0, n_tests = 0, n_smp = 0;
	adcc_top u_adcc_top (.CLK_SYS(clk), .RESETN(rstn), .ADDR(addr),
		.WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat), .GLOBAL_IRQ_EN(gie),
		.IRQ_ACK(ack), .IRQ(irq), .ANA_RESULT(res), .ANA_POWER(pwr),
		.ANA_SAMPLE(smp), .ANA_HIGH_SPEED(hs), .ANA_CHANNEL(ch),
		.ANA_REF(rf));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (smp === 1'b1) n_smp++;
	task chk(input logic [7:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task w(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask : w
	task rc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdat, e);
	endtask : rc
	// start, expect busy before n ticks of k cycles, done after
	task conv(input logic [7:0] c, input int n, k);
		w(0, c);
		cyc((n - 2) * k);
		rc(0, (c | 8'h40) & 8'hef);
		cyc(3 * k);
		rc(0, (c & 8'haf) | 8'h10);
	endtask : conv
	task t_first;
		for (int a = 0; a < 6; a++) rc(3'(a), 8'h00);
		conv(8'hd0, 25, 2);
		rc(1, 8'hd5);
		rc(2, 8'h02);
		w(3, 8'h20);
		rc(1, 8'h40);
		rc(2, 8'hb5);
		w(3, 8'h00);
	endtask : t_first
	task t_div;
		for (int i = 1; i < 8; i++) conv(8'hd0 | 8'(i), 13, 1 << i);
		w(4, 8'h10);
		#1 chk(8'(hs), 8'h01);
		conv(8'hd2, 13, 2);
		rc(4, 8'h10);
		w(4, 8'h00);
	endtask : t_div
	task t_zero;
		w(0, 8'hd0);
		w(0, 8'h80);
		rc(0, 8'hc0);
		cyc(40);
		w(0, 8'h80);
		rc(0, 8'h90);
	endtask : t_zero
	task t_irq;
		@(posedge clk) gie <= 1;
		w(0, 8'h88);
		cyc(2);
		#1 chk(8'(irq), 8'h01);
		@(posedge clk) ack <= 1;
		@(posedge clk) ack <= 0;
		rc(0, 8'h88);
		chk(8'(irq), 8'h00);
		@(posedge clk) gie <= 0;
	endtask : t_irq
	task t_free;
		n_smp = 0;
		w(0, 8'hf0);
		cyc(100);
		chk(8'(n_smp >= 3), 8'h01);
		w(0, 8'h90);
		cyc(40);
		n_smp = 0;
		cyc(60);
		chk(8'(n_smp), 8'h00);
	endtask : t_free
	task t_abort;
		w(0, 8'hd0);
		cyc(10);
		w(0, 8'h00);
		rc(0, 8'h00);
		chk(8'(pwr), 8'h00);
		conv(8'hd0, 25, 2);
	endtask : t_abort
	task t_lock;
		rc(1, 8'hd5);
		@(posedge clk) res <= 10'h155;
		w(0, 8'hd0);
		cyc(40);
		rc(0, 8'h80);
		rc(2, 8'h02);
		conv(8'hd0, 13, 2);
		rc(1, 8'h55);
		rc(2, 8'h01);
	endtask : t_lock
	// selection written mid-conversion, applied after completion
	task t_sel;
		@(posedge clk) res <= 10'h3ff;
		w(0, 8'hd0);
		w(3, 8'hc5);
		#1 chk(8'(ch), 8'h00);
		chk(8'(rf), 8'h00);
		cyc(40);
		#1 chk(8'(ch), 8'h05);
		chk(8'(rf), 8'h03);
		rc(1, 8'hff);
		rc(2, 8'h03);
		w(3, 8'h00);
	endtask : t_sel
	task report_and_stop;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#500000;
		err_count++;
		report_and_stop;
	end
	initial
	begin
		cyc(12);
		rstn <= 1;
		t_first;
		t_div;
		t_zero;
		t_irq;
		t_free;
		t_abort;
		t_lock;
		t_sel;
		report_and_stop;
	end
endmodule : tb_adcc_top
